// ===== mim_pkg.sv
package mim_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h30;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h31ff_ffff;
    localparam int RXU_LSB = 28;
    localparam int RXH_LSB = 16;
    localparam int TXSEL_BIT = 15;
    localparam int TXTHR_LSB = 12;
    localparam int TXCNT_LSB = 8;
    localparam int RXSEL_BIT = 7;
    localparam int RXTHR_LSB = 4;
    localparam int RXL_LSB = 0;
    localparam int ISR_TX_BIT = 4;
    localparam int ISR_RX_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Tick periods in ns, as printed
    localparam int CLK_NS = 40;
    localparam int TICK_SHORT_FAST_NS = 5120;
    localparam int TICK_LONG_FAST_NS = 81920;
    localparam int TICK_SHORT_SLOW_NS = 51200;
    localparam int TICK_LONG_SLOW_NS = 819200;
    localparam int TICK_SHORT_FAST_CYC = TICK_SHORT_FAST_NS / CLK_NS;
    localparam int TICK_LONG_FAST_CYC = TICK_LONG_FAST_NS / CLK_NS;
    localparam int TICK_SHORT_SLOW_CYC = TICK_SHORT_SLOW_NS / CLK_NS;
    localparam int TICK_LONG_SLOW_CYC = TICK_LONG_SLOW_NS / CLK_NS;

    typedef struct packed {
        logic [1:0] rx_threshold_unit;
        logic [8:0] rx_wait_count_upper;
        logic tx_tick_period_select;
        logic [2:0] tx_packet_threshold;
        logic [3:0] tx_wait_count;
        logic rx_tick_period_select;
        logic [2:0] rx_packet_threshold;
        logic [3:0] rx_wait_count_lower;
    } mim_ctrl_s;

    typedef struct packed {
        logic done;
        logic irq_request;
    } mim_pkt_s;
endpackage

// ===== mim_dir.sv
`timescale 1ns/1ns
`default_nettype none
// One direction of coalescing: packet counter, tick divider, wait timer
module mim_dir #(
    parameter int CNT_W = 9,
    parameter int WAIT_W = 13,
    parameter int DIV_W = 15
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Settings
    input wire logic [CNT_W-1:0] threshold_in,
    input wire logic [WAIT_W-1:0] wait_count_in,
    input wire logic [DIV_W-1:0] tick_cycles_in,
    input wire logic per_pkt_mode_in,
    // Events
    input wire mim_pkg::mim_pkt_s pkt_in,
    output logic irq_out
);
    typedef struct packed {
        logic [CNT_W-1:0] pkts;
        logic [WAIT_W-1:0] timer;
        logic [DIV_W-1:0] div;
        logic irq;
    } mim_dir_s;

    mim_dir_s st;
    mim_dir_s next_st;

    always_comb begin
        logic fire;
        logic tick;
        logic thr_on;
        logic wait_on;
        fire = 1'b0;
        next_st = st;
        thr_on = (threshold_in != '0);
        wait_on = (wait_count_in != '0);
        tick = (st.div >= tick_cycles_in - DIV_W'(1));
        next_st.div = tick ? '0 : st.div + DIV_W'(1);
        if (pkt_in.done) begin
            // Saturate so a long timer wait cannot wrap to idle
            if (st.pkts != '1) begin
                next_st.pkts = st.pkts + CNT_W'(1);
            end
            if (st.pkts == '0) begin
                next_st.timer = '0;
                next_st.div = '0;
            end
        end
        if (!thr_on && !wait_on) begin
            // Not coalescing: no stale count for a later mode change
            next_st.pkts = '0;
            fire = pkt_in.done && per_pkt_mode_in;
        end else begin
            if (thr_on && pkt_in.done &&
                    st.pkts + CNT_W'(1) >= threshold_in) begin
                fire = 1'b1;
            end
            // Timer runs only while packets are pending
            if (wait_on && st.pkts != '0 && tick) begin
                next_st.timer = st.timer + WAIT_W'(1);
                if (st.timer + WAIT_W'(1) >= wait_count_in) begin
                    fire = 1'b1;
                end
            end
        end
        if (fire) begin
            next_st.pkts = '0;
            next_st.timer = '0;
        end
        next_st.irq = fire;
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign irq_out = st.irq;
endmodule
`default_nettype wire

// ===== mim_top.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module mim_top (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // MAC events, same clock
    input wire logic speed_100_in,
    input wire mim_pkg::mim_pkt_s tx_pkt_in,
    input wire mim_pkg::mim_pkt_s rx_pkt_in,
    // Coalesced interrupts, one-cycle pulses
    output logic [31:0] interrupt_status_reg_out
);
    typedef struct packed {
        mim_pkg::mim_ctrl_s ctrl;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } mim_top_s;

    mim_top_s st;
    mim_top_s next_st;
    logic tx_irq;
    logic rx_irq;

    function automatic logic [14:0] tick_cycles(input logic long_sel,
            input logic fast);
        int c;
        if (fast) begin
            c = long_sel ? mim_pkg::TICK_LONG_FAST_CYC
                    : mim_pkg::TICK_SHORT_FAST_CYC;
        end else begin
            c = long_sel ? mim_pkg::TICK_LONG_SLOW_CYC
                    : mim_pkg::TICK_SHORT_SLOW_CYC;
        end
        return c[14:0];
    endfunction

    function automatic logic [31:0] ctrl_word(input mim_pkg::mim_ctrl_s c);
        logic [31:0] w;
        w = '0;
        w[mim_pkg::RXU_LSB +: 2] = c.rx_threshold_unit;
        w[mim_pkg::RXH_LSB +: 9] = c.rx_wait_count_upper;
        w[mim_pkg::TXSEL_BIT] = c.tx_tick_period_select;
        w[mim_pkg::TXTHR_LSB +: 3] = c.tx_packet_threshold;
        w[mim_pkg::TXCNT_LSB +: 4] = c.tx_wait_count;
        w[mim_pkg::RXSEL_BIT] = c.rx_tick_period_select;
        w[mim_pkg::RXTHR_LSB +: 3] = c.rx_packet_threshold;
        w[mim_pkg::RXL_LSB +: 4] = c.rx_wait_count_lower;
        return w;
    endfunction

    function automatic mim_pkg::mim_ctrl_s word_ctrl(input logic [31:0] w);
        mim_pkg::mim_ctrl_s c;
        c.rx_threshold_unit = w[mim_pkg::RXU_LSB +: 2];
        c.rx_wait_count_upper = w[mim_pkg::RXH_LSB +: 9];
        c.tx_tick_period_select = w[mim_pkg::TXSEL_BIT];
        c.tx_packet_threshold = w[mim_pkg::TXTHR_LSB +: 3];
        c.tx_wait_count = w[mim_pkg::TXCNT_LSB +: 4];
        c.rx_tick_period_select = w[mim_pkg::RXSEL_BIT];
        c.rx_packet_threshold = w[mim_pkg::RXTHR_LSB +: 3];
        c.rx_wait_count_lower = w[mim_pkg::RXL_LSB +: 4];
        return c;
    endfunction

    always_comb begin
        logic [31:0] old_w;
        logic [31:0] new_w;
        old_w = ctrl_word(st.ctrl);
        new_w = old_w;
        next_st = st;
        if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            if (st.aw_addr[7:2] == mim_pkg::ADDR_CTRL[7:2]) begin
                for (int i = 0; i < 4; i++) begin
                    if (st.w_strb[i]) begin
                        new_w[i*8 +: 8] = st.w_data[i*8 +: 8];
                    end
                end
                new_w = new_w & mim_pkg::CTRL_WMASK;
                next_st.ctrl = word_ctrl(new_w);
                next_st.bresp = mim_pkg::RESP_OKAY;
            end else begin
                next_st.bresp = mim_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            if (s_axi_araddr[7:2] == mim_pkg::ADDR_CTRL[7:2]) begin
                next_st.rdata = old_w;
                next_st.rresp = mim_pkg::RESP_OKAY;
            end else begin
                next_st.rdata = '0;
                next_st.rresp = mim_pkg::RESP_SLVERR;
            end
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = !st.aw_held;
    assign s_axi_wready = !st.w_held;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;

    logic [8:0] rx_thr_scaled;
    logic [12:0] rx_wait_count;
    logic [14:0] tx_tick;
    logic [14:0] rx_tick;

    // Shift of 0, 2, 4 or 6 gives 1, 4, 16 or 64 packets per step
    assign rx_thr_scaled = 9'({6'h00, st.ctrl.rx_packet_threshold}
            << {st.ctrl.rx_threshold_unit, 1'b0});
    assign rx_wait_count = {st.ctrl.rx_wait_count_upper,
            st.ctrl.rx_wait_count_lower};
    assign tx_tick = tick_cycles(st.ctrl.tx_tick_period_select,
            speed_100_in);
    assign rx_tick = tick_cycles(st.ctrl.rx_tick_period_select,
            speed_100_in);

    mim_dir #(.CNT_W(9), .WAIT_W(13), .DIV_W(15)) u_tx (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .threshold_in({6'h00, st.ctrl.tx_packet_threshold}),
        .wait_count_in({9'h000, st.ctrl.tx_wait_count}),
        .tick_cycles_in(tx_tick),
        .per_pkt_mode_in(tx_pkt_in.irq_request),
        .pkt_in(tx_pkt_in),
        .irq_out(tx_irq)
    );

    mim_dir #(.CNT_W(9), .WAIT_W(13), .DIV_W(15)) u_rx (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .threshold_in(rx_thr_scaled),
        .wait_count_in(rx_wait_count),
        .tick_cycles_in(rx_tick),
        .per_pkt_mode_in(1'b1),
        .pkt_in(rx_pkt_in),
        .irq_out(rx_irq)
    );

    always_comb begin
        interrupt_status_reg_out = '0;
        interrupt_status_reg_out[mim_pkg::ISR_TX_BIT] = tx_irq;
        interrupt_status_reg_out[mim_pkg::ISR_RX_BIT] = rx_irq;
    end
endmodule
`default_nettype wire

// ===== mim_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mim_top_checker (
    // Watched ports
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] interrupt_status_reg_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    AST_STATUS_RESV: assert property (
        (interrupt_status_reg_out & 32'hffff_ffee) == 32'h0)
        else $error("status bit outside 4 and 0");
    AST_RDATA_RESV: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:30] == 2'h0
        && s_axi_rdata[27:25] == 3'h0)
        else $error("reserved read bits set");
    AST_READ_UNMAPPED: assert property (
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] != mim_pkg::ADDR_CTRL[7:2]
        |=> s_axi_rvalid && s_axi_rresp == mim_pkg::RESP_SLVERR
            && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_READ_MAPPED: assert property (
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] == mim_pkg::ADDR_CTRL[7:2]
        |=> s_axi_rvalid && s_axi_rresp == mim_pkg::RESP_OKAY)
        else $error("control read not okay");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    AST_WRITE_RESP: assert property (
        // Both held one edge after being taken, answer one edge later
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && (!s_axi_bvalid || s_axi_bready) |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RESET_QUIET: assert property (
        $rose(arst_n_in) |-> interrupt_status_reg_out == 32'h0
        && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy after reset");
endmodule
bind mim_top mim_top_checker mim_top_checker_inst (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .interrupt_status_reg_out(interrupt_status_reg_out)
);
`default_nettype wire

// ===== mim_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mim_top_bench;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, interrupt_status_reg_out;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, speed_100_in = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    mim_pkg::mim_pkt_s tx_pkt_in = '0, rx_pkt_in = '0;
    int n_errors = 0, cmp_count = 0, tx_hits = 0, rx_hits = 0, cyc = 0;
    logic [15:0] seed = 16'h001b;
    logic [31:0] rd, wd;
    int t, n, ex;
    mim_top mim_top_inst (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .speed_100_in(speed_100_in),
        .tx_pkt_in(tx_pkt_in),
        .rx_pkt_in(rx_pkt_in),
        .interrupt_status_reg_out(interrupt_status_reg_out)
    );
    always #20 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) begin
        tx_hits += int'(interrupt_status_reg_out[4]);
        rx_hits += int'(interrupt_status_reg_out[0]);
    end
    // Longest path is the tick sweep, about 48k cycles of a run near 58k
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int tick(input bit sel, input bit fast);
        if (sel)
            return fast ? mim_pkg::TICK_LONG_FAST_CYC
                    : mim_pkg::TICK_LONG_SLOW_CYC;
        return fast ? mim_pkg::TICK_SHORT_FAST_CYC
                : mim_pkg::TICK_SHORT_SLOW_CYC;
    endfunction
    // Release each channel only at the edge that took it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, b;
        @(posedge clk_sys_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(negedge clk_sys_in);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys_in);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end while (!b);
        s_axi_bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        bit ar, r;
        @(posedge clk_sys_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(negedge clk_sys_in);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys_in);
            if (ar) s_axi_arvalid <= 0;
        end while (!r);
        s_axi_rready <= 0;
    endtask
    // Done stays high for k edges: k packets back to back
    task automatic burst(input bit tx, input int k, input logic req);
        @(posedge clk_sys_in);
        if (tx) tx_pkt_in <= '{1'b1, req};
        else rx_pkt_in <= '{1'b1, req};
        repeat (k) @(posedge clk_sys_in);
        tx_pkt_in <= '0;
        rx_pkt_in <= '0;
        repeat (3) @(posedge clk_sys_in);
    endtask
    task automatic timed(input bit tx, input int lo, input int hi);
        int c = 0;
        tx_hits = 0;
        rx_hits = 0;
        burst(tx, 1, 1'b0);
        while ((tx ? tx_hits : rx_hits) == 0 && c <= hi) begin
            @(posedge clk_sys_in);
            c++;
        end
        check(32'(c + 3 >= lo && c <= hi), 32'h1);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        arst_n_in <= 1;
        rdr(mim_pkg::ADDR_CTRL);
        check(rd, mim_pkg::CTRL_RESET);
        rdr(8'h34);
        check(32'(resp), 32'(mim_pkg::RESP_SLVERR));
        check(rd, 32'h0);
        wr(8'h34, 32'hffff_ffff);
        check(32'(resp), 32'(mim_pkg::RESP_SLVERR));
        repeat (4) begin
            seed = lfsr(seed);
            wd[31:16] = seed;
            seed = lfsr(seed);
            wd = {wd[31:16], seed};
            wr(mim_pkg::ADDR_CTRL, wd);
            rdr(mim_pkg::ADDR_CTRL);
            check(rd, wd & mim_pkg::CTRL_WMASK);
        end
        wr(mim_pkg::ADDR_CTRL, 32'h0);
        seed = lfsr(seed);
        n = int'(seed[2:0]) + 1;
        rx_hits = 0;
        burst(0, n, 1'b0);
        check(rx_hits, n);
        tx_hits = 0;
        ex = 0;
        repeat (8) begin
            seed = lfsr(seed);
            burst(1, 1, seed[0]);
            ex += int'(seed[0]);
        end
        check(tx_hits, ex);
        wr(mim_pkg::ADDR_CTRL, 32'h0000_2000);
        tx_hits = 0;
        burst(1, 2, 1'b0);
        burst(1, 3, 1'b0);
        check(tx_hits, 2);
        for (int u = 0; u < 4; u++) begin
            wr(mim_pkg::ADDR_CTRL, (u << mim_pkg::RXU_LSB) | 32'h10);
            rx_hits = 0;
            if (u > 0) burst(0, (1 << (2 * u)) - 1, 1'b0);
            check(rx_hits, 0);
            burst(0, 1, 1'b0);
            check(rx_hits, 1);
        end
        rx_hits = 0;
        burst(0, 1, 1'b0);
        repeat (3000) @(posedge clk_sys_in);
        check(rx_hits, 0);
        wr(mim_pkg::ADDR_CTRL, 32'h0);
        burst(0, 1, 1'b0);
        burst(1, 1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            speed_100_in <= i[0];
            wr(mim_pkg::ADDR_CTRL, 32'h3200 | (i[1] << mim_pkg::TXSEL_BIT));
            t = tick(i[1], i[0]);
            timed(1, 2 * t, 2 * t + 4);
        end
        speed_100_in <= 1;
        wr(mim_pkg::ADDR_CTRL, 32'h0001_0000);
        t = tick(0, 1);
        timed(0, 16 * t, 16 * t + 4);
        wr(mim_pkg::ADDR_CTRL, 32'h0000_0082);
        t = tick(1, 1);
        timed(0, 2 * t, 2 * t + 4);
        // Reset in mid-run must drop the nonzero control word
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        rdr(mim_pkg::ADDR_CTRL);
        check(rd, mim_pkg::CTRL_RESET);
        tally_and_finish();
    end
endmodule
`default_nettype wire
